/* core/tsso_pkg.sv */
package tsso_pkg;

    // ========================================================================
    // Object indices.
    localparam logic [15:0] IDX_LONG_DIFF16 = 16'h6014;
    localparam logic [15:0] IDX_LAT_SLOPE16 = 16'h6020;
    localparam logic [15:0] IDX_LAT_CTRL = 16'h6021;
    localparam logic [15:0] IDX_LAT_PRESET16 = 16'h6022;
    localparam logic [15:0] IDX_LAT_AUTO16 = 16'h6023;
    localparam logic [15:0] IDX_LAT_DIFF16 = 16'h6024;
    localparam logic [15:0] IDX_LONG_SLOPE32 = 16'h6110;
    localparam logic [15:0] IDX_LONG_DIFF32 = 16'h6114;
    localparam logic [15:0] IDX_LAT_SLOPE32 = 16'h6120;
    localparam logic [15:0] IDX_LAT_CTRL32 = 16'h6121;
    localparam logic [15:0] IDX_LAT_PRESET32 = 16'h6122;
    localparam logic [15:0] IDX_LAT_AUTO32 = 16'h6123;
    localparam logic [15:0] IDX_LAT_DIFF32 = 16'h6124;
    localparam logic [15:0] IDX_PRESET_Y = 16'h2601;

    // ========================================================================
    // Field positions and reset values.
    localparam int CTRL_INV_BIT = 0;
    localparam int CTRL_SCALE_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] PRESET_RESET = 16'h0000;
    localparam logic [15:0] OFFSET16_RESET = 16'h0000;
    localparam logic [31:0] OFFSET32_RESET = 32'h0000_0000;

    // ========================================================================
    // Resolution codes and count limits.
    localparam logic [15:0] RES_CODE_1DEG = 16'h0001;
    localparam logic [15:0] RES_CODE_01DEG = 16'h0002;
    localparam logic [15:0] RES_CODE_001DEG = 16'h000A;
    localparam logic [15:0] LIM_1DEG = 16'h0050;
    localparam logic [15:0] LIM_01DEG = 16'h0320;
    localparam logic [15:0] LIM_001DEG = 16'h1F40;

    // ========================================================================
    // Object access request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [31:0] wdata;
    } tsso_od_req_t;

endpackage

/* core/tsso_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tsso_top
    import tsso_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire tsso_od_req_t od_req_in,
    input wire logic [15:0] resolution_in,
    input wire logic [15:0] lateral_raw_in,
    input wire logic [15:0] long_base16_in,
    input wire logic [31:0] long_base32_in,
    input wire logic long_scale_en_in,
    output logic od_ack_out,
    output logic od_err_out,
    output logic [31:0] od_rdata_out,
    output logic [15:0] lateral_tilt_count_out,
    output logic [31:0] lateral_tilt_wide_out,
    output logic [15:0] longitudinal_tilt_count_out,
    output logic [31:0] longitudinal_tilt_wide_out
);

    // ========================================================================
    // Helper functions.
    function automatic logic [15:0] res_limit(input logic [15:0] res);
        logic [15:0] lim;
        lim = LIM_001DEG;
        if (res == RES_CODE_1DEG)
        begin
            lim = LIM_1DEG;
        end
        else if (res == RES_CODE_01DEG)
        begin
            lim = LIM_01DEG;
        end
        return lim;
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
        logic [15:0] r;
        logic [15:0] nlim;
        r = v;
        nlim = 16'h0000 - lim;
        if ($signed(v) > $signed(lim))
        begin
            r = lim;
        end
        else if ($signed(v) < $signed(nlim))
        begin
            r = nlim;
        end
        return r;
    endfunction

    function automatic logic [31:0] sext(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // ========================================================================
    // Stored objects.
    logic [7:0] lat_ctrl;
    logic [15:0] lat_preset;
    logic [15:0] lat_auto;
    logic [15:0] lat_diff;
    logic [31:0] long_diff;
    logic [7:0] next_lat_ctrl;
    logic [15:0] next_lat_preset;
    logic [15:0] next_lat_auto;
    logic [15:0] next_lat_diff;
    logic [31:0] next_long_diff;
    logic next_ack;
    logic next_err;
    logic [31:0] next_rdata;

    logic inv_on;
    logic scale_on;
    logic [15:0] lat_neg;
    logic [15:0] lat_signed;
    logic [15:0] lat_sum;
    logic [15:0] lat_result;
    logic [15:0] lat_lim;
    logic [15:0] next_lat_count;
    logic [15:0] next_long_count;
    logic [31:0] next_long_wide;
    logic preset_wr;

    // ========================================================================
    // Lateral datapath.
    always_comb
    begin
        inv_on = lat_ctrl[CTRL_INV_BIT];
        scale_on = lat_ctrl[CTRL_SCALE_BIT];
        lat_neg = 16'h0000 - lateral_raw_in;
        lat_signed = inv_on ? lat_neg : lateral_raw_in;
        lat_sum = lat_signed + lat_auto + lat_diff;
        lat_result = scale_on ? lat_sum : lat_signed;
        lat_lim = res_limit(resolution_in);
        next_lat_count = clamp16(lat_result, lat_lim);
    end

    // ========================================================================
    // Longitudinal datapath.
    always_comb
    begin
        next_long_count = long_base16_in;
        next_long_wide = long_base32_in;
        if (long_scale_en_in)
        begin
            next_long_count = long_base16_in + long_diff[15:0];
            next_long_wide = long_base32_in + long_diff;
        end
    end

    // ========================================================================
    // Object dictionary access.
    always_comb
    begin
        next_lat_ctrl = lat_ctrl;
        next_lat_preset = lat_preset;
        next_lat_auto = lat_auto;
        next_lat_diff = lat_diff;
        next_long_diff = long_diff;
        next_ack = od_req_in.rd | od_req_in.wr;
        next_err = 1'b0;
        next_rdata = 32'h0000_0000;
        preset_wr = 1'b0;
        if (od_req_in.wr)
        begin
            unique case (od_req_in.index)
                IDX_LONG_DIFF16: next_long_diff = sext(od_req_in.wdata[15:0]);
                IDX_LONG_DIFF32: next_long_diff = od_req_in.wdata;
                IDX_LAT_CTRL, IDX_LAT_CTRL32: next_lat_ctrl = od_req_in.wdata[7:0];
                IDX_LAT_PRESET16, IDX_LAT_PRESET32, IDX_PRESET_Y:
                begin
                    preset_wr = 1'b1;
                end
                IDX_LAT_DIFF16, IDX_LAT_DIFF32: next_lat_diff = od_req_in.wdata[15:0];
                default: next_err = 1'b1;
            endcase
            if (preset_wr)
            begin
                next_lat_preset = od_req_in.wdata[15:0];
                next_lat_auto = od_req_in.wdata[15:0] - lat_signed;
            end
        end
        else if (od_req_in.rd)
        begin
            unique case (od_req_in.index)
                IDX_LONG_DIFF16: next_rdata = {16'h0000, long_diff[15:0]};
                IDX_LAT_SLOPE16: next_rdata = {16'h0000, lateral_tilt_count_out};
                IDX_LAT_CTRL: next_rdata = {24'h00_0000, lat_ctrl};
                IDX_LAT_PRESET16, IDX_PRESET_Y: next_rdata = {16'h0000, lat_preset};
                IDX_LAT_AUTO16: next_rdata = {16'h0000, lat_auto};
                IDX_LAT_DIFF16: next_rdata = {16'h0000, lat_diff};
                IDX_LONG_SLOPE32: next_rdata = longitudinal_tilt_wide_out;
                IDX_LONG_DIFF32: next_rdata = long_diff;
                IDX_LAT_SLOPE32: next_rdata = lateral_tilt_wide_out;
                IDX_LAT_CTRL32: next_rdata = {24'h00_0000, lat_ctrl};
                IDX_LAT_PRESET32: next_rdata = sext(lat_preset);
                IDX_LAT_AUTO32: next_rdata = sext(lat_auto);
                IDX_LAT_DIFF32: next_rdata = sext(lat_diff);
                default: next_err = 1'b1;
            endcase
        end
    end

    // ========================================================================
    // State registers.
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            lat_ctrl <= CTRL_RESET;
            lat_preset <= PRESET_RESET;
            lat_auto <= OFFSET16_RESET;
            lat_diff <= OFFSET16_RESET;
            long_diff <= OFFSET32_RESET;
            od_ack_out <= 1'b0;
            od_err_out <= 1'b0;
            od_rdata_out <= 32'h0000_0000;
            lateral_tilt_count_out <= 16'h0000;
            lateral_tilt_wide_out <= 32'h0000_0000;
            longitudinal_tilt_count_out <= 16'h0000;
            longitudinal_tilt_wide_out <= 32'h0000_0000;
        end
        else
        begin
            lat_ctrl <= next_lat_ctrl;
            lat_preset <= next_lat_preset;
            lat_auto <= next_lat_auto;
            lat_diff <= next_lat_diff;
            long_diff <= next_long_diff;
            od_ack_out <= next_ack;
            od_err_out <= next_err;
            od_rdata_out <= next_rdata;
            lateral_tilt_count_out <= next_lat_count;
            lateral_tilt_wide_out <= sext(next_lat_count);
            longitudinal_tilt_count_out <= next_long_count;
            longitudinal_tilt_wide_out <= next_long_wide;
        end
    end

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence seq_preset_write;
        od_req_in.wr && (od_req_in.index == IDX_LAT_PRESET16 ||
            od_req_in.index == IDX_LAT_PRESET32 || od_req_in.index == IDX_PRESET_Y);
    endsequence

    sequence seq_diff_write;
        od_req_in.wr && (od_req_in.index == IDX_LAT_DIFF16 ||
            od_req_in.index == IDX_LAT_DIFF32);
    endsequence

    sequence seq_ctrl_write;
        od_req_in.wr && (od_req_in.index == IDX_LAT_CTRL ||
            od_req_in.index == IDX_LAT_CTRL32);
    endsequence

    sequence seq_long16_write;
        od_req_in.wr && od_req_in.index == IDX_LONG_DIFF16;
    endsequence

    a_long_gate: assert property (
        ##1 longitudinal_tilt_count_out == ($past(long_scale_en_in) ?
            $past(long_base16_in) + $past(long_diff[15:0]) : $past(long_base16_in)))
        else $error("longitudinal offset gating wrong");

    a_lat_limit: assert property (
        ##1 ($signed(lateral_tilt_count_out) <= $signed($past(lat_lim)) &&
            $signed(lateral_tilt_count_out) >= -$signed($past(lat_lim))))
        else $error("lateral count outside resolution limit");

    a_inv_only: assert property (
        (lat_ctrl == 8'h01 && $signed(lat_neg) <= $signed(lat_lim) &&
            $signed(lat_neg) >= -$signed(lat_lim))
        |=> lateral_tilt_count_out == $past(16'h0000 - lateral_raw_in))
        else $error("inverted lateral result wrong");

    a_scale_sum: assert property (
        (lat_ctrl == 8'h02 && lat_sum == clamp16(lat_sum, lat_lim))
        |=> lateral_tilt_count_out == $past(lateral_raw_in + lat_auto + lat_diff))
        else $error("scaled lateral result wrong");

    a_auto_recalc: assert property (
        seq_preset_write |=> lat_auto == $past(od_req_in.wdata[15:0] - lat_signed) &&
            lat_preset == $past(od_req_in.wdata[15:0]))
        else $error("automatic offset not recomputed");

    a_diff_user: assert property (
        !(od_req_in.wr && (od_req_in.index == IDX_LAT_DIFF16 ||
            od_req_in.index == IDX_LAT_DIFF32)) |=> $stable(lat_diff))
        else $error("differential offset changed without write");

    a_diff_store: assert property (
        seq_diff_write |=> lat_diff == $past(od_req_in.wdata[15:0]))
        else $error("differential offset not stored");

    a_wide_mirror: assert property (
        lateral_tilt_wide_out == {{16{lateral_tilt_count_out[15]}}, lateral_tilt_count_out})
        else $error("wide lateral view differs");

    a_long_wide: assert property (
        !long_scale_en_in ##1 1'b1 |-> longitudinal_tilt_wide_out == $past(long_base32_in))
        else $error("wide longitudinal offset applied while disabled");

    a_ro_refused: assert property (
        od_req_in.wr && od_req_in.index == IDX_LAT_SLOPE16 |=> od_ack_out && od_err_out)
        else $error("write to read-only count not refused");

    a_ctrl_store: assert property (
        seq_ctrl_write |=> lat_ctrl == $past(od_req_in.wdata[7:0]))
        else $error("lateral control byte not stored");

    a_long_sext: assert property (
        seq_long16_write |=> long_diff == {{16{$past(od_req_in.wdata[15])}},
            $past(od_req_in.wdata[15:0])})
        else $error("narrow longitudinal offset not sign extended");

    a_plain_pass: assert property (
        (lat_ctrl == 8'h00 && lateral_raw_in == clamp16(lateral_raw_in, lat_lim))
        |=> lateral_tilt_count_out == $past(lateral_raw_in))
        else $error("plain lateral result wrong");

    a_inv_scaled: assert property (
        (lat_ctrl == 8'h03 && lat_sum == clamp16(lat_sum, lat_lim))
        |=> lateral_tilt_count_out == $past(16'h0000 - lateral_raw_in + lat_auto + lat_diff))
        else $error("inverted scaled lateral result wrong");

    a_long_wide_on: assert property (
        long_scale_en_in |=> longitudinal_tilt_wide_out == $past(long_base32_in + long_diff))
        else $error("wide longitudinal offset not applied");

    a_auto_ro: assert property (
        od_req_in.wr && od_req_in.index == IDX_LAT_AUTO16 |=> od_err_out && $stable(lat_auto))
        else $error("read-only automatic offset was written");

    a_req_answer: assert property (
        (od_req_in.rd || od_req_in.wr) |=> od_ack_out)
        else $error("object request not answered");

endmodule
`default_nettype wire

/* verification/tsso_master.sv */
`timescale 1ns/1ps
`default_nettype none
module tsso_master
    import tsso_pkg::*;
(
    input wire logic clk_in,
    output var tsso_od_req_t od_req_out
);
    // ========================================
    // Object request driver.
    initial
    begin
        od_req_out = '0;
    end

    // Holds one request through the edge that takes it.
    task automatic send(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    begin
        od_req_out.rd = !wr;
        od_req_out.wr = wr;
        od_req_out.index = idx;
        od_req_out.wdata = d;
        @(posedge clk_in);
        #1;
    end
    endtask

    task automatic idle();
    begin
        od_req_out.rd = 1'b0;
        od_req_out.wr = 1'b0;
        @(posedge clk_in);
        #1;
    end
    endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsso_pkg::*;
    logic clk_in, nrst_in, lse, ack, err;
    tsso_od_req_t od_req;
    logic [15:0] res, x, lb16, lc16, lat16, pre, dif, auto_o;
    logic [31:0] lb32, rdata, lat32, lc32;
    logic [7:0] ctl;
    int n_fail, samples_checked, cycles;
    logic [32:0] notes[$];
    logic [15:0] ro_idx[6] = '{16'h6020, 16'h6023, 16'h6110, 16'h6120, 16'h6123, 16'h6025};
    logic [15:0] codes[3] = '{16'h0001, 16'h0002, 16'h000A};
    int steps[3] = '{100, 10, 1};

    tsso_master master (.clk_in(clk_in), .od_req_out(od_req));
    tsso_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .od_req_in(od_req),
        .resolution_in(res), .lateral_raw_in(x), .long_base16_in(lb16),
        .long_base32_in(lb32), .long_scale_en_in(lse), .od_ack_out(ack),
        .od_err_out(err), .od_rdata_out(rdata), .lateral_tilt_count_out(lat16),
        .lateral_tilt_wide_out(lat32), .longitudinal_tilt_count_out(lc16),
        .longitudinal_tilt_wide_out(lc32));

    // ========================================
    // Comparison and closing.
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask

    task automatic give_verdict();
    begin
        $display("TB: checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // ========================================
    // Object access and lateral model.
    task automatic obj_wr(input logic [15:0] idx, input logic [31:0] d, input logic e);
    begin
        notes.push_back({e, 32'h0000_0000});
        master.send(1'b1, idx, d);
    end
    endtask

    task automatic obj_rd(input logic [15:0] idx, input logic [32:0] exp);
    begin
        notes.push_back(exp);
        master.send(1'b0, idx, 32'h0000_0000);
    end
    endtask

    function automatic logic [15:0] lat_exp();
        logic [15:0] v;
        logic [15:0] lim;
        v = ctl[0] ? 16'h0000 - x : x;
        if (ctl[1])
            v = v + auto_o + dif;
        lim = res == 16'h0001 ? LIM_1DEG : (res == 16'h0002 ? LIM_01DEG : LIM_001DEG);
        if ($signed(v) > $signed(lim))
            v = lim;
        else if ($signed(v) < -$signed(lim))
            v = 16'h0000 - lim;
        return v;
    endfunction

    task automatic dp_check();
        logic [15:0] e;
    begin
        repeat (2) @(posedge clk_in);
        #1;
        e = lat_exp();
        check({17'h0_0000, lat16}, {17'h0_0000, e});
        check({1'b0, lat32}, {1'b0, {16{e[15]}}, e});
    end
    endtask

    // ========================================
    // Answer watcher and timeout.
    always @(negedge clk_in)
    begin
        cycles++;
        if (ack === 1'b1)
            check({err, rdata}, notes.size() > 0 ? notes.pop_front() : 33'h1_FFFF_FFFF);
        if (cycles == 4000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    initial
    begin
        {nrst_in, lse, ctl, pre, dif, auto_o, x, lb16, lb32} = '0;
        res = RES_CODE_001DEG;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        void'($urandom(58220));
        repeat (5) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        obj_rd(IDX_LAT_CTRL, 33'h0_0000_0000);
        obj_rd(IDX_LAT_PRESET16, 33'h0_0000_0000);
        $display("TB: reset values done");
        for (int i = 0; i < 4; i++)
        begin
            x = 16'($urandom_range(4000)) - 16'h07D0;
            ctl = 8'(i);
            obj_wr(IDX_LAT_CTRL, {24'h00_0000, ctl}, 1'b0);
            pre = 16'($urandom_range(4000)) - 16'h07D0;
            obj_wr(i == 1 ? IDX_PRESET_Y : (i == 2 ? IDX_LAT_PRESET32 : IDX_LAT_PRESET16),
                {16'h0000, pre}, 1'b0);
            auto_o = pre - (ctl[0] ? 16'h0000 - x : x);
            dif = 16'($urandom_range(2000)) - 16'h03E8;
            obj_wr(IDX_LAT_DIFF16, {16'h0000, dif}, 1'b0);
            obj_rd(IDX_LAT_AUTO16, {17'h0_0000, auto_o});
            obj_rd(IDX_LAT_AUTO32, {1'b0, {16{auto_o[15]}}, auto_o});
            obj_rd(IDX_LAT_DIFF16, {17'h0_0000, dif});
            master.idle();
            dp_check();
        end
        $display("TB: scaling modes done");
        ctl = 8'h01;
        obj_wr(IDX_LAT_CTRL, 32'h0000_0001, 1'b0);
        master.idle();
        for (int r = 0; r < 3; r++)
        begin
            res = codes[r];
            x = 16'h8000;
            dp_check();
            x = 16'h8001;
            dp_check();
            check({1'b0, 32'($signed(lat16) * steps[r])}, 33'h0_0000_1F40);
        end
        $display("TB: clamping done");
        obj_rd(IDX_LAT_SLOPE16, 33'h0_0000_1F40);
        obj_rd(IDX_LAT_SLOPE32, 33'h0_0000_1F40);
        foreach (ro_idx[k])
            obj_wr(ro_idx[k], 32'h0000_1234, 1'b1);
        obj_rd(IDX_LAT_AUTO16, {17'h0_0000, auto_o});
        $display("TB: refusals done");
        lb16 = 16'h0064;
        lb32 = 32'h0000_0064;
        obj_wr(IDX_LONG_DIFF16, 32'h0000_FFF6, 1'b0);
        master.idle();
        dp_check();
        check({1'b0, lc16, lc32[15:0]}, {1'b0, 32'h0064_0064});
        lse = 1'b1;
        dp_check();
        check({1'b0, lc16, lc32[15:0]}, {1'b0, 32'h005A_005A});
        obj_wr(IDX_LONG_DIFF32, 32'hFFFF_B9B1, 1'b0);
        obj_rd(IDX_LONG_DIFF16, 33'h0_0000_B9B1);
        obj_rd(IDX_LONG_DIFF32, 33'h0_FFFF_B9B1);
        master.idle();
        dp_check();
        check({1'b0, lc32}, 33'h0_FFFF_BA15);
        check({17'h0_0000, lc16}, 33'h0_0000_BA15);
        $display("TB: longitudinal offset done");
        master.idle();
        check({1'b0, 32'(notes.size())}, 33'h0_0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
